// *** common/dacs_pkg.sv ***
// Shared types and constants for the dual converter sequencer
package dacs_pkg;
    localparam int NUM_CH      = 16;
    localparam int NUM_PAIR    = 8;
    localparam int NUM_EXT     = 8;
    localparam int NUM_INT     = 8;
    localparam int RES_W       = 12;
    localparam int WIN_W       = 6;
    localparam int CONV_CYC    = 13;
    localparam logic [1:0] SRC_EXT  = 2'h0;
    localparam logic [1:0] SRC_INT1 = 2'h1;
    localparam logic [1:0] SRC_INT2 = 2'h2;
    localparam logic [2:0] MUXB_LOWREF = 3'h4;
    localparam logic [11:0] RESULT_RST = 12'h000;

    typedef struct packed {
        logic [2:0]       trigger_select;
        logic [2:0]       input_select;
        logic [2:0]       input_select_b;
        logic [WIN_W-1:0] window;
    } dacs_chan_cfg_t;

    typedef struct packed {
        logic [3:0] chan;
        logic [4:0] int_idx;
    } dacs_int_map_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] chan;
        logic       paired;
        logic [2:0] mux_a;
        logic [2:0] mux_b;
    } dacs_analog_t;
endpackage

// *** rtl/dacs_converter.sv ***
// One converter's sequencer: triggers, priority, sampling, results, interrupts
// ---------------------------------------------------------------
// What this block does
// - Sixteen channels, own trigger, input, window.
// - Pair bit n covers channels 2n, 2n+1.
// - Sequential pair channels configure and store separately.
// - Paired: even config used, odd ignored.
// - Any mix of pair settings allowed.
// - Two sample-holds, separate input muxes.
// - Eight external trigger lines per converter.
// - Internal triggers from first, second interrupts.
// - External trigger chosen by trigger select.
// - One conversion at a time, priority ordered.
// - Mux A selects one of six inputs.
// - Mux B: four inputs plus low reference.
// - Sample for converted channel's window.
// - Sixteen result registers per converter.
// - Channels mapped onto eight completion interrupts.
// - Interrupts ANDed across converters (top level).
// - Results shared; configuration control-CPU only.
// ---------------------------------------------------------------
`timescale 1ns/1ps
module dacs_converter
    import dacs_pkg::*;
(
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic [NUM_EXT-1:0]             ext_trig_sync,
    input  wire dacs_chan_cfg_t [NUM_CH-1:0]    channel_conv_control,
    input  wire logic [NUM_PAIR-1:0]            pair_mode_select,
    input  wire logic [NUM_CH-1:0]              internal_trigger_select_lo,
    input  wire logic [NUM_CH-1:0]              internal_trigger_select_hi,
    input  wire logic [3:0]                     conversion_priority_control,
    input  wire dacs_int_map_t [NUM_INT-1:0]    eoc_interrupt_map,
    input  wire logic [RES_W-1:0]               sample_a_data,
    input  wire logic [RES_W-1:0]               sample_b_data,
    output logic [NUM_CH-1:0][RES_W-1:0]        conv_result,
    output logic [NUM_INT-1:0]                  eoc_int,
    output dacs_analog_t                        analog,
    output logic                                sample_hold,
    output logic                                busy
);
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV, ST_STORE} dacs_state_t;

    typedef struct packed {
        dacs_state_t                 st;
        logic [NUM_CH-1:0]           pend;
        logic [NUM_CH-1:0]           trig_prev;
        logic [WIN_W-1:0]            cnt;
        logic [3:0]                  chan;
        logic                        paired;
        logic [NUM_CH-1:0][RES_W-1:0] res;
        logic [NUM_INT-1:0]          ints;
        dacs_analog_t                ana;
        logic [3:0]                  rr;
        logic                        sh;
        logic                        bz;
    } dacs_conv_state_t;

    dacs_conv_state_t s_q, s_d;

    // ---------------------------------------------------------------
    // Trigger selection per channel
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] trig_lvl;
    logic [NUM_CH-1:0] eff_odd_off;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_trig
            // Own config even for odd channels; a paired odd one is masked below
            localparam int CFG = g;
            logic [1:0] src;
            always_comb begin
                src = {internal_trigger_select_hi[CFG], internal_trigger_select_lo[CFG]};
                case (src)
                    SRC_INT1: trig_lvl[g] = s_q.ints[0];
                    SRC_INT2: trig_lvl[g] = s_q.ints[1];
                    default:  trig_lvl[g] = ext_trig_sync[channel_conv_control[CFG].trigger_select];
                endcase
            end
            // Paired odd channels never raise their own request
            assign eff_odd_off[g] = (g % 2 == 1) && pair_mode_select[g/2];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [NUM_CH-1:0] req;
        logic              found;
        logic [3:0]        idx;
        logic [3:0]        start;
        dacs_chan_cfg_t    cfg;
        logic [NUM_CH-1:0] cand;
        req   = '0;
        cand  = '0;
        found = 1'b0;
        idx   = '0;
        start = '0;
        cfg   = '0;
        s_d   = s_q;
        s_d.trig_prev = trig_lvl;
        // Set on rising edge wins over clear by grant
        req = trig_lvl & ~s_q.trig_prev & ~eff_odd_off;
        // A stale odd request waits until its pair is split again
        cand = s_q.pend & ~eff_odd_off;
        // Priority: channels below the boundary are fixed high priority,
        // the rest share round-robin so none starves
        for (int i = 0; i < NUM_CH; i++) begin
            if (!found && cand[i] && 4'(i) < conversion_priority_control) begin
                found = 1'b1;
                idx   = 4'(i);
            end
        end
        start = (s_q.rr < conversion_priority_control) ? conversion_priority_control : s_q.rr;
        for (int k = 0; k < NUM_CH; k++) begin
            if (!found && cand[4'(start + 4'(k))] && (4'(start + 4'(k)) >= conversion_priority_control)) begin
                found = 1'b1;
                idx   = 4'(start + 4'(k));
            end
        end
        s_d.ints = '0;
        case (s_q.st)
            ST_IDLE: begin
                if (found) begin
                    cfg          = channel_conv_control[idx];
                    s_d.st       = ST_SAMPLE;
                    s_d.chan     = idx;
                    s_d.paired   = pair_mode_select[idx[3:1]];
                    s_d.cnt      = cfg.window;
                    s_d.pend[idx] = 1'b0;
                    s_d.rr       = 4'(idx + 4'h1);
                    s_d.ana.valid  = 1'b1;
                    s_d.ana.chan   = idx;
                    s_d.ana.paired = pair_mode_select[idx[3:1]];
                    s_d.ana.mux_a  = (cfg.input_select > 3'h5) ? 3'h5 : cfg.input_select;
                    s_d.ana.mux_b  = (cfg.input_select_b > MUXB_LOWREF) ? MUXB_LOWREF
                                                                      : cfg.input_select_b;
                end
            end
            ST_SAMPLE: begin
                if (s_q.cnt == '0) begin
                    s_d.st  = ST_CONV;
                    s_d.cnt = WIN_W'(CONV_CYC);
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            ST_CONV: begin
                if (s_q.cnt == '0) begin
                    s_d.st = ST_STORE;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            ST_STORE: begin
                s_d.st        = ST_IDLE;
                s_d.ana.valid = 1'b0;
                s_d.res[s_q.chan] = sample_a_data;
                if (s_q.paired) begin
                    s_d.res[{s_q.chan[3:1], 1'b1}] = sample_b_data;
                end
                for (int j = 0; j < NUM_INT; j++) begin
                    if (!eoc_interrupt_map[j].int_idx[4] &&
                        (eoc_interrupt_map[j].chan == s_q.chan ||
                         (s_q.paired && eoc_interrupt_map[j].chan == {s_q.chan[3:1], 1'b1}))) begin
                        s_d.ints[j] = 1'b1;
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        s_d.pend = s_d.pend | req;
        // Registered decodes keep the status outputs glitch free
        s_d.sh   = (s_d.st == ST_SAMPLE);
        s_d.bz   = (s_d.st != ST_IDLE);
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Results are plain storage; any reader may sample them
    assign conv_result = s_q.res;
    assign eoc_int     = s_q.ints;
    assign analog      = s_q.ana;
    assign sample_hold = s_q.sh;
    assign busy        = s_q.bz;
endmodule

// ---------------------------------------------------------------
// Two converters and the combined interrupts
// ---------------------------------------------------------------
module dacs_top
    import dacs_pkg::*;
(
    input  wire logic                                clk_sys,
    input  wire logic                                rst,
    input  wire logic [1:0][NUM_EXT-1:0]             ext_trig,
    input  wire logic                                ctl_cpu_wr,
    input  wire dacs_chan_cfg_t [1:0][NUM_CH-1:0]    channel_conv_control,
    input  wire logic [1:0][NUM_PAIR-1:0]            pair_mode_select,
    input  wire logic [1:0][NUM_CH-1:0]              internal_trigger_select_lo,
    input  wire logic [1:0][NUM_CH-1:0]              internal_trigger_select_hi,
    input  wire logic [1:0][3:0]                     conversion_priority_control,
    input  wire dacs_int_map_t [1:0][NUM_INT-1:0]    eoc_interrupt_map,
    input  wire logic [1:0][RES_W-1:0]               sample_a_data,
    input  wire logic [1:0][RES_W-1:0]               sample_b_data,
    output logic [1:0][NUM_CH-1:0][RES_W-1:0]        conv_result,
    output logic [NUM_INT-1:0]                       eoc_int_combined,
    output dacs_analog_t [1:0]                       analog,
    output logic [1:0]                               sample_hold,
    output logic [1:0]                               busy
);
    // Configuration held locally, loaded only by the control CPU strobe
    typedef struct packed {
        logic [1:0][NUM_EXT-1:0]          s1;
        logic [1:0][NUM_EXT-1:0]          s2;
        dacs_chan_cfg_t [1:0][NUM_CH-1:0] cc;
        logic [1:0][NUM_PAIR-1:0]         pm;
        logic [1:0][NUM_CH-1:0]           lo;
        logic [1:0][NUM_CH-1:0]           hi;
        logic [1:0][3:0]                  pr;
        dacs_int_map_t [1:0][NUM_INT-1:0] im;
        logic [NUM_INT-1:0]               ic;
    } dacs_top_state_t;

    dacs_top_state_t t_q, t_d;
    logic [1:0][NUM_INT-1:0] ints;

    // ---------------------------------------------------------------
    // Configuration copy and trigger synchronisers
    // ---------------------------------------------------------------
    // Raw trigger pins may be metastable, so two flops come before edge detection
    always_comb begin
        t_d    = t_q;
        t_d.s1 = ext_trig;
        t_d.s2 = t_q.s1;
        if (ctl_cpu_wr) begin
            t_d.cc = channel_conv_control;
            t_d.pm = pair_mode_select;
            t_d.lo = internal_trigger_select_lo;
            t_d.hi = internal_trigger_select_hi;
            t_d.pr = conversion_priority_control;
            t_d.im = eoc_interrupt_map;
        end
        t_d.ic = ints[0] & ints[1];
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign eoc_int_combined = t_q.ic;

    // ---------------------------------------------------------------
    // Converter instances
    // ---------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_conv
            dacs_converter u_conv (
                .clk_sys                    (clk_sys),
                .rst                        (rst),
                .ext_trig_sync              (t_q.s2[c]),
                .channel_conv_control       (t_q.cc[c]),
                .pair_mode_select           (t_q.pm[c]),
                .internal_trigger_select_lo (t_q.lo[c]),
                .internal_trigger_select_hi (t_q.hi[c]),
                .conversion_priority_control(t_q.pr[c]),
                .eoc_interrupt_map          (t_q.im[c]),
                .sample_a_data              (sample_a_data[c]),
                .sample_b_data              (sample_b_data[c]),
                .conv_result                (conv_result[c]),
                .eoc_int                    (ints[c]),
                .analog                     (analog[c]),
                .sample_hold                (sample_hold[c]),
                .busy                       (busy[c])
            );
        end
    endgenerate
endmodule

// *** sim/dacs_top_asserts.sv ***
// Port checker for the dual converter sequencer
`timescale 1ns/1ps
module dacs_top_asserts
    import dacs_pkg::*;
(
    input wire logic                              clk_sys,
    input wire logic                              rst,
    input wire logic [1:0][NUM_CH-1:0][RES_W-1:0] conv_result,
    input wire logic [NUM_INT-1:0]                eoc_int_combined,
    input wire dacs_analog_t [1:0]                analog,
    input wire logic [1:0]                        sample_hold,
    input wire logic [1:0]                        busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----
    // Relations
    // ----
    mux_a_range_a: assert property (
        analog[0].valid |-> analog[0].mux_a <= 3'h5) else $error("mux a out of range");
    mux_b_range_a: assert property (
        analog[1].valid |-> analog[1].mux_b <= 3'h4) else $error("mux b out of range");
    one_conv_a: assert property (
        sample_hold[0] |-> busy[0] && analog[0].valid) else $error("sampling while idle");
    eoc_pulse_a: assert property (
        |eoc_int_combined |=> eoc_int_combined == '0) else $error("interrupt longer than a cycle");
    conv_span_a: assert property (
        $fell(sample_hold[0]) |-> (busy[0] && !sample_hold[0])[*8]) else $error("conversion cut short");
    result_update_a: assert property (
        $changed(conv_result[0]) |-> $past(busy[0]) && !busy[0]) else $error("result changed early");
    sample_stable_a: assert property (
        sample_hold[1] && $past(sample_hold[1]) |-> $stable(analog[1])) else $error("mux moved in sampling");
    odd_refused_a: assert property (
        analog[1].valid && analog[1].paired |-> !analog[1].chan[0]) else $error("odd channel paired");
    eoc_both_a: assert property (
        |eoc_int_combined |-> $past(busy, 2) == 2'h3) else $error("interrupt without both done");
    cover property ($rose(sample_hold[0]));
    cover property (analog[1].valid && analog[1].paired);
    cover property (|eoc_int_combined);
endmodule

// *** sim/dacs_analog_model.sv ***
// Analog front end model for both converters
`timescale 1ns/1ps
module dacs_analog_model
    import dacs_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire dacs_analog_t [1:0] analog,
    output logic [1:0][RES_W-1:0]   sample_a_data,
    output logic [1:0][RES_W-1:0]   sample_b_data
);
    logic [RES_W-1:0] noise = 12'h000;
    // Idle lines wander so stale data never passes for a sample
    always @(posedge clk_sys) noise <= noise + 12'h5a3;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            sample_a_data[c] = analog[c].valid ? {c[0], 8'ha5, analog[c].mux_a} : noise;
            sample_b_data[c] = !analog[c].valid ? ~noise : (analog[c].mux_b == MUXB_LOWREF) ? 12'h000 :
                {c[0], 8'h3c, analog[c].mux_b};
        end
    end
endmodule

// *** sim/test_dacs_top.sv ***
// Self-checking bench for the dual converter sequencer
`timescale 1ns/1ps
module test_dacs_top;
    import dacs_pkg::*;
    logic                              clk_sys = 1'b0;
    logic                              rst = 1'b1;
    logic                              wr = 1'b0;
    logic [1:0][NUM_EXT-1:0]           trig = '0;
    dacs_chan_cfg_t [1:0][NUM_CH-1:0]  cfg;
    logic [1:0][NUM_PAIR-1:0]          pair = '0;
    logic [1:0][NUM_CH-1:0]            isl = '0;
    logic [1:0][NUM_CH-1:0]            ish = '0;
    logic [1:0][3:0]                   prio = {4'hf, 4'hf};
    dacs_int_map_t [1:0][NUM_INT-1:0]  imap;
    logic [1:0][RES_W-1:0]             sa, sb;
    logic [1:0][NUM_CH-1:0][RES_W-1:0] res;
    logic [NUM_INT-1:0]                eoc, seen;
    dacs_analog_t [1:0]                ana;
    logic [1:0]                        sh, busy;
    int                                error_cnt = 0, compares = 0, tot = 0;
    dacs_top uut (.clk_sys(clk_sys), .rst(rst), .ext_trig(trig), .ctl_cpu_wr(wr),
        .channel_conv_control(cfg), .pair_mode_select(pair), .internal_trigger_select_lo(isl),
        .internal_trigger_select_hi(ish), .conversion_priority_control(prio),
        .eoc_interrupt_map(imap), .sample_a_data(sa), .sample_b_data(sb), .conv_result(res),
        .eoc_int_combined(eoc), .analog(ana), .sample_hold(sh), .busy(busy));
    dacs_analog_model fe (.clk_sys(clk_sys), .analog(ana), .sample_a_data(sa), .sample_b_data(sb));
    always #50 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        tot += $countones(eoc) + ($isunknown(eoc) ? 1000 : 0);
        seen |= eoc;
    end
    // ----
    // Helpers
    // ----
    function automatic logic [RES_W-1:0] va(input logic c, input logic [2:0] m);
        return {c, 8'ha5, m};
    endfunction
    function automatic logic [RES_W-1:0] vb(input logic c, input logic [2:0] m);
        return {c, 8'h3c, m};
    endfunction
    task automatic chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t result %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        compares++;
        if (got != exp) begin
            error_cnt++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic fire(input logic [15:0] m);
        @(posedge clk_sys);
        trig <= m;
        repeat (2) @(posedge clk_sys);
        trig <= '0;
    endtask
    // Waits for both converters to stay idle, pending chains included
    task automatic settle;
        int q = 0;
        for (int i = 0; i < 3000 && q < 8; i++) begin
            @(negedge clk_sys);
            q = (busy === 2'b00) ? q + 1 : 0;
        end
    endtask
    task automatic hold_len(input int exp);
        int n = 0;
        for (int i = 0; i < 20 && sh[0] !== 1'b1; i++) @(negedge clk_sys);
        while (sh[0] === 1'b1 && n < 99) begin
            @(negedge clk_sys);
            n++;
        end
        chk_n(n, exp);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_seq;
        tot = 0;
        fire(16'h0010);
        hold_len(8);
        settle();
        chk(res[0][4], va(0, 3'h4));
        chk(res[0][12], va(0, 3'h0));
        chk(res[0][5], RESULT_RST);
        fire(16'h0020);
        hold_len(9);
        settle();
        chk(res[0][5], va(0, 3'h5));
        chk(res[0][4], va(0, 3'h4));
        chk_n(tot, 0);
    endtask
    task automatic t_pair;
        @(posedge clk_sys);
        pair[1] <= 8'h04;
        cfg[1][4].input_select_b <= 3'h2;
        fire(16'h2000);
        settle();
        chk(res[1][5], RESULT_RST);
        chk(res[1][13], va(1, 3'h1));
        fire(16'h1000);
        settle();
        chk(res[1][4], va(1, 3'h4));
        chk(res[1][5], vb(1, 3'h2));
        @(posedge clk_sys);
        cfg[1][4].input_select_b <= MUXB_LOWREF;
        fire(16'h1000);
        settle();
        chk(res[1][5], 12'h000);
    endtask
    task automatic t_all;
        @(posedge clk_sys);
        pair <= '0;
        tot = 0;
        seen = '0;
        fire(16'hffff);
        settle();
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < NUM_CH; k++)
                chk(res[c][k], va(c[0], 3'(k % 6)));
        chk_n(tot, NUM_INT);
        chk_n(int'(seen), 255);
    endtask
    task automatic t_int;
        @(posedge clk_sys);
        imap[0][0].chan <= 4'h8;
        imap[0][1].chan <= 4'h9;
        isl[0] <= 16'h0005;
        ish[0] <= 16'h0006;
        cfg[0][0].input_select <= 3'h5;
        cfg[0][1].input_select <= 3'h3;
        cfg[0][2].input_select <= 3'h4;
        fire(16'h0001);
        settle();
        chk(res[0][0], va(0, 3'h5));
        chk(res[0][1], va(0, 3'h1));
        fire(16'h0002);
        settle();
        chk(res[0][1], va(0, 3'h3));
        fire(16'h0004);
        settle();
        chk(res[0][2], va(0, 3'h4));
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < NUM_CH; k++) begin
                cfg[c][k] = '{3'(k), 3'(k % 6), 3'(k % 5), 6'(k + 3)};
                imap[c][k % NUM_INT] = '{4'(k % NUM_INT), 5'(k % NUM_INT)};
            end
        seen = '0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        wr <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_seq();
        t_pair();
        t_all();
        t_int();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
endmodule
bind dacs_top dacs_top_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .conv_result(conv_result),
    .eoc_int_combined(eoc_int_combined), .analog(analog), .sample_hold(sample_hold), .busy(busy));
